/* File: hdl/aitime_engine.sv */
// analog input timing and triggering engine
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module aitime_engine
  import aitime_pkg::*;
(
  input  wire logic                    clock_i,
  input  wire logic                    rst_i,
  input  wire logic [3:0]              reg_addr_i,
  input  wire logic [31:0]             reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [31:0]             reg_rdata_o,
  input  wire aitime_term_t            term_i,
  output aitime_route_t                route_o,
  output logic                         adc_start_o,
  output logic                         sample_store_o,
  output logic                         sample_discard_o,
  output logic                         acq_active_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  aitime_term_t meta_r;
  aitime_term_t sync_r;
  aitime_term_t prev_r;

  // first stage is read only by the second stage
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= term_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [AITIME_SRC_W-1:0] src_r;
  logic [AITIME_CNT_W-1:0] scan_div_r;
  logic [AITIME_CNT_W-1:0] conv_div_r;
  logic [AITIME_CNT_W-1:0] conv_dly_r;
  logic [AITIME_CH_W-1:0]  nchan_r;
  logic [AITIME_CNT_W-1:0] buf_sz_r;
  logic [AITIME_CNT_W-1:0] pre_cnt_r;
  logic                    wr_ctrl;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == AITIME_REG_CTRL);

  // configuration registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      src_r      <= '0;
      scan_div_r <= AITIME_DIV_RST;
      conv_div_r <= AITIME_DIV_RST;
      conv_dly_r <= AITIME_CDLY_RST;
      nchan_r    <= AITIME_NCHAN_RST;
      buf_sz_r   <= AITIME_BUF_RST;
      pre_cnt_r  <= AITIME_PRE_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        AITIME_REG_SRC:     src_r      <= reg_wdata_i[AITIME_SRC_W-1:0];
        AITIME_REG_SCANDIV: scan_div_r <= reg_wdata_i[AITIME_CNT_W-1:0];
        AITIME_REG_CONVDIV: conv_div_r <= reg_wdata_i[AITIME_CNT_W-1:0];
        AITIME_REG_CONVDLY: conv_dly_r <= reg_wdata_i[AITIME_CNT_W-1:0];
        AITIME_REG_NCHAN:   nchan_r    <= reg_wdata_i[AITIME_CH_W-1:0];
        AITIME_REG_BUFSZ:   buf_sz_r   <= reg_wdata_i[AITIME_CNT_W-1:0];
        AITIME_REG_PRETRIG: pre_cnt_r  <= reg_wdata_i[AITIME_CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // edge detection and timebases
  // ----------------------------------------------------------------
  function automatic logic edge_f(input logic cur, input logic prv, input logic fall);
    edge_f = fall ? (prv && !cur) : (cur && !prv);
  endfunction : edge_f

  logic       begin_edge;
  logic       stop_edge;
  logic       scan_ext_edge;
  logic       conv_ext_edge;
  logic       stb_tick;
  logic       ctr_edge;
  logic       tb20_tick;
  logic       ctb_tick;
  logic [2:0] tb20_acc_r;

  assign begin_edge    = edge_f(sync_r.begin_trig, prev_r.begin_trig, src_r[AITIME_SRC_BEGIN_FALL]);
  assign stop_edge     = edge_f(sync_r.stop_trig, prev_r.stop_trig, src_r[AITIME_SRC_STOP_FALL]);
  assign scan_ext_edge = edge_f(sync_r.scan_ext, prev_r.scan_ext, src_r[AITIME_SRC_SCAN_FALL]);
  assign conv_ext_edge = edge_f(sync_r.conv_ext, prev_r.conv_ext, src_r[AITIME_SRC_CONV_FALL]);
  assign stb_tick      = edge_f(sync_r.scan_tb, prev_r.scan_tb, src_r[AITIME_SRC_STB_FALL]);
  assign ctr_edge      = edge_f(sync_r.ctr_out, prev_r.ctr_out, 1'b0);
  // conversion timebase stays internal, no output exists for it
  assign ctb_tick      = src_r[AITIME_SRC_CTB_SEL] ? stb_tick : tb20_tick;

  // fractional accumulator: two ticks every five clocks gives 20 MHz on average
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tb20_acc_r <= '0;
    end else if (tb20_acc_r + AITIME_TB20_ACC >= AITIME_TB20_MOD) begin
      tb20_acc_r <= 3'(tb20_acc_r + AITIME_TB20_ACC - AITIME_TB20_MOD);
    end else begin
      tb20_acc_r <= 3'(tb20_acc_r + AITIME_TB20_ACC);
    end
  end
  assign tb20_tick = (tb20_acc_r + AITIME_TB20_ACC >= AITIME_TB20_MOD);

  // ----------------------------------------------------------------
  // acquisition control
  // ----------------------------------------------------------------
  aitime_acq_t             acq_r;
  logic [AITIME_CNT_W-1:0] samp_cnt_r;
  logic [AITIME_CNT_W-1:0] fill_r;
  logic                    scan_acc;
  logic                    running;
  logic                    sw_start;
  logic                    sw_stop;
  logic                    begin_hit;
  logic                    start_acq;
  logic                    count_done;

  assign sw_start  = wr_ctrl && reg_wdata_i[AITIME_CTRL_SW_START];
  assign sw_stop   = wr_ctrl && reg_wdata_i[AITIME_CTRL_SW_STOP];
  assign begin_hit = src_r[AITIME_SRC_BEGIN_HW] ? begin_edge : sw_start;
  assign running   = (acq_r == AITIME_PRE) || (acq_r == AITIME_WATCH) ||
                     (acq_r == AITIME_POST) || (acq_r == AITIME_RUN);
  // a hardware begin edge only counts once software has armed; a stop in the same cycle wins
  assign start_acq  = begin_hit && !sw_stop &&
                      ((acq_r == AITIME_IDLE && !src_r[AITIME_SRC_BEGIN_HW]) || acq_r == AITIME_ARMED);
  // a finished count refuses the strobe that would slip in before the state moves on
  assign count_done = (samp_cnt_r == '0) &&
                      (acq_r == AITIME_POST || (acq_r == AITIME_RUN && !src_r[AITIME_SRC_CONTINUOUS]));

  // samples are counted at scan acceptance
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      acq_r      <= AITIME_IDLE;
      samp_cnt_r <= '0;
    end else if (sw_stop) begin
      acq_r <= AITIME_IDLE;
    end else begin
      case (acq_r)
        AITIME_IDLE: begin
          if (sw_start && src_r[AITIME_SRC_BEGIN_HW]) begin
            acq_r <= AITIME_ARMED;
          end else if (start_acq) begin
            acq_r      <= src_r[AITIME_SRC_STOP_EN] ? AITIME_PRE : AITIME_RUN;
            samp_cnt_r <= src_r[AITIME_SRC_STOP_EN] ? pre_cnt_r : buf_sz_r;
          end
        end
        AITIME_ARMED: begin
          if (start_acq) begin
            acq_r      <= src_r[AITIME_SRC_STOP_EN] ? AITIME_PRE : AITIME_RUN;
            samp_cnt_r <= src_r[AITIME_SRC_STOP_EN] ? pre_cnt_r : buf_sz_r;
          end
        end
        AITIME_PRE: begin
          if (samp_cnt_r == '0) begin
            acq_r <= AITIME_WATCH;
          end else if (scan_acc) begin
            samp_cnt_r <= samp_cnt_r - AITIME_CNT_ONE;
          end
        end
        AITIME_WATCH: begin
          // pretrigger count reached: now a stop edge counts
          if (stop_edge) begin
            acq_r      <= AITIME_POST;
            samp_cnt_r <= 24'(buf_sz_r - pre_cnt_r);
          end
        end
        AITIME_POST: begin
          if (samp_cnt_r == '0) begin
            acq_r <= AITIME_IDLE;
          end else if (scan_acc) begin
            samp_cnt_r <= samp_cnt_r - AITIME_CNT_ONE;
          end
        end
        AITIME_RUN: begin
          if (!src_r[AITIME_SRC_CONTINUOUS]) begin
            if (samp_cnt_r == '0) begin
              acq_r <= AITIME_IDLE;
            end else if (scan_acc) begin
              samp_cnt_r <= samp_cnt_r - AITIME_CNT_ONE;
            end
          end
        end
        default: acq_r <= AITIME_IDLE;
      endcase
    end
  end

  // buffer fill level; oldest dropped once full while waiting for the stop trigger
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fill_r <= '0;
    end else if (start_acq) begin
      fill_r <= '0;
    end else if (scan_acc && fill_r != buf_sz_r) begin
      fill_r <= fill_r + AITIME_CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // scan strobe generation
  // ----------------------------------------------------------------
  logic [AITIME_CNT_W-1:0] scan_cnt_r;
  logic                    scan_div_hit;
  logic                    scan_raw;
  logic                    shared;

  assign shared       = src_r[AITIME_SRC_SHARED];
  assign scan_div_hit = stb_tick && (scan_cnt_r == '0);

  // scan divider runs only during an acquisition
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scan_cnt_r <= '0;
    end else if (!running) begin
      scan_cnt_r <= scan_div_r;
    end else if (stb_tick) begin
      scan_cnt_r <= (scan_cnt_r == '0) ? scan_div_r : scan_cnt_r - AITIME_CNT_ONE;
    end
  end

  always_comb begin
    case (src_r[AITIME_SRC_SCAN_SEL +: 2])
      AITIME_SEL_DIVIDED: scan_raw = scan_div_hit;
      AITIME_SEL_COUNTER: scan_raw = ctr_edge;
      AITIME_SEL_EXT:     scan_raw = scan_ext_edge;
      default:            scan_raw = wr_ctrl && reg_wdata_i[AITIME_CTRL_SW_SCAN];
    endcase
    if (shared) begin
      scan_raw = conv_ext_edge;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  logic                    in_scan_r;
  logic [AITIME_CH_W-1:0]  conv_left_r;
  logic [AITIME_CNT_W-1:0] conv_cnt_r;
  logic                    conv_int;
  logic                    conv_raw;
  logic                    conv_acc;
  logic                    last_conv;

  // gating: nothing before begin trigger, one scan at a time
  assign scan_acc  = running && !count_done && scan_raw && (!in_scan_r || shared);
  assign conv_int  = in_scan_r && ctb_tick && (conv_cnt_r == '0);
  always_comb begin
    case (src_r[AITIME_SRC_CONV_SEL +: 2])
      AITIME_SEL_DIVIDED: conv_raw = conv_int;
      AITIME_SEL_COUNTER: conv_raw = ctr_edge;
      default:            conv_raw = conv_ext_edge;
    endcase
  end
  // shared mode: every external tick is a single conversion
  assign conv_acc  = running && (shared ? scan_acc : (in_scan_r && conv_raw));
  assign last_conv = (conv_left_r == AITIME_CH_ONE);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      in_scan_r   <= 1'b0;
      conv_left_r <= '0;
    end else if (!running) begin
      in_scan_r <= 1'b0;
    end else if (scan_acc && !shared) begin
      in_scan_r   <= 1'b1;
      conv_left_r <= nchan_r;
    end else if (conv_acc && !shared) begin
      conv_left_r <= conv_left_r - AITIME_CH_ONE;
      in_scan_r   <= !last_conv;
    end
  end

  // internal conversion divider: first reload is the scan-to-conversion delay
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      conv_cnt_r <= '0;
    end else if (scan_acc || !in_scan_r) begin
      conv_cnt_r <= conv_dly_r - AITIME_CNT_ONE;
    end else if (ctb_tick) begin
      conv_cnt_r <= (conv_cnt_r == '0) ? conv_div_r - AITIME_CNT_ONE : conv_cnt_r - AITIME_CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic scan_store_r;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      adc_start_o      <= 1'b0;
      route_o          <= '0;
      route_o.conv_strobe_n <= 1'b1;
      sample_store_o   <= 1'b0;
      sample_discard_o <= 1'b0;
      acq_active_o     <= 1'b0;
      scan_store_r     <= 1'b0;
    end else begin
      adc_start_o           <= conv_acc;
      route_o.conv_strobe_n <= !conv_acc;
      route_o.scan_strobe   <= scan_acc;
      // hold pulse one clock after conversion start
      route_o.hold_done     <= adc_start_o ^ src_r[AITIME_SRC_HOLD_LOW];
      route_o.begin_pulse   <= start_acq;
      route_o.stop_pulse    <= stop_edge && (acq_r == AITIME_WATCH);
      scan_store_r          <= scan_acc;
      sample_store_o        <= scan_store_r;
      sample_discard_o      <= scan_acc && (acq_r == AITIME_WATCH) && (fill_r == buf_sz_r);
      acq_active_o          <= running;
    end
  end

  // ----------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        AITIME_REG_SRC:     reg_rdata_o <= 32'(src_r);
        AITIME_REG_SCANDIV: reg_rdata_o <= 32'(scan_div_r);
        AITIME_REG_CONVDIV: reg_rdata_o <= 32'(conv_div_r);
        AITIME_REG_CONVDLY: reg_rdata_o <= 32'(conv_dly_r);
        AITIME_REG_NCHAN:   reg_rdata_o <= 32'(nchan_r);
        AITIME_REG_BUFSZ:   reg_rdata_o <= 32'(buf_sz_r);
        AITIME_REG_PRETRIG: reg_rdata_o <= 32'(pre_cnt_r);
        AITIME_REG_STATUS:  reg_rdata_o <= {24'h000000, conv_left_r[3:0], in_scan_r, acq_r};
        AITIME_REG_SCNT:    reg_rdata_o <= 32'(samp_cnt_r);
        default:            reg_rdata_o <= '0;
      endcase
    end
  end

endmodule : aitime_engine

/* File: hdl/aitime_pkg.sv */
// package: register map, field layouts and constants of the analog input timing engine
package aitime_pkg;

  // ----------------------------------------------------------------
  // register indices (word addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] AITIME_REG_CTRL    = 4'h0;
  localparam logic [3:0] AITIME_REG_SRC     = 4'h1;
  localparam logic [3:0] AITIME_REG_SCANDIV = 4'h2;
  localparam logic [3:0] AITIME_REG_CONVDIV = 4'h3;
  localparam logic [3:0] AITIME_REG_CONVDLY = 4'h4;
  localparam logic [3:0] AITIME_REG_NCHAN   = 4'h5;
  localparam logic [3:0] AITIME_REG_BUFSZ   = 4'h6;
  localparam logic [3:0] AITIME_REG_PRETRIG = 4'h7;
  localparam logic [3:0] AITIME_REG_STATUS  = 4'h8;
  localparam logic [3:0] AITIME_REG_SCNT    = 4'h9;

  // ----------------------------------------------------------------
  // control register bits (write only commands, none stored)
  // ----------------------------------------------------------------
  localparam int AITIME_CTRL_SW_START = 0;  // command pulse
  localparam int AITIME_CTRL_SW_STOP  = 1;  // command pulse
  localparam int AITIME_CTRL_SW_SCAN  = 2;  // command pulse

  // ----------------------------------------------------------------
  // source / mode register bits
  // ----------------------------------------------------------------
  localparam int AITIME_SRC_BEGIN_HW    = 0;  // 1: hardware begin trigger, 0: software
  localparam int AITIME_SRC_BEGIN_FALL  = 1;
  localparam int AITIME_SRC_STOP_EN     = 2;  // stop-trigger (pretrigger) acquisition
  localparam int AITIME_SRC_STOP_FALL   = 3;
  localparam int AITIME_SRC_SCAN_SEL    = 4;  // 2 bits: scan strobe source
  localparam int AITIME_SRC_SCAN_FALL   = 6;
  localparam int AITIME_SRC_CONV_SEL    = 7;  // 2 bits: conversion strobe source
  localparam int AITIME_SRC_CONV_FALL   = 9;
  localparam int AITIME_SRC_CTB_SEL     = 10; // 1: scan timebase, 0: 20 MHz timebase
  localparam int AITIME_SRC_STB_FALL    = 11; // scan timebase active edge
  localparam int AITIME_SRC_HOLD_LOW    = 12; // hold-done pulse active low
  localparam int AITIME_SRC_CONTINUOUS  = 13;
  localparam int AITIME_SRC_SHARED      = 14; // one external signal as scan and conversion
  localparam int AITIME_SRC_W           = 15;

  // strobe source encodings
  localparam logic [1:0] AITIME_SEL_DIVIDED = 2'h0;
  localparam logic [1:0] AITIME_SEL_COUNTER = 2'h1;
  localparam logic [1:0] AITIME_SEL_EXT     = 2'h2;
  localparam logic [1:0] AITIME_SEL_SW      = 2'h3;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int AITIME_CNT_W = 24;
  localparam int AITIME_CH_W  = 8;
  localparam logic [AITIME_CNT_W-1:0] AITIME_DIV_RST   = 24'h000004;
  localparam logic [AITIME_CNT_W-1:0] AITIME_CDLY_RST  = 24'h000003; // three timebase ticks
  localparam logic [AITIME_CH_W-1:0]  AITIME_NCHAN_RST = 8'h01;
  localparam logic [AITIME_CNT_W-1:0] AITIME_BUF_RST   = 24'h000010;
  localparam logic [AITIME_CNT_W-1:0] AITIME_PRE_RST   = 24'h000004;
  localparam logic [AITIME_CNT_W-1:0] AITIME_CNT_ONE   = 24'h000001;
  localparam logic [AITIME_CH_W-1:0]  AITIME_CH_ONE    = 8'h01;

  // 20 MHz internal timebase from the 50 MHz clock: period 50 ns
  localparam int AITIME_CLK_HZ   = 50_000_000;
  localparam int AITIME_TB20_HZ  = 20_000_000;
  localparam logic [2:0] AITIME_TB20_ACC = 3'(AITIME_TB20_HZ / 10_000_000); // add 2
  localparam logic [2:0] AITIME_TB20_MOD = 3'(AITIME_CLK_HZ / 10_000_000);  // wrap at 5

  // acquisition states
  typedef enum logic [2:0] {
    AITIME_IDLE,
    AITIME_ARMED,
    AITIME_PRE,
    AITIME_WATCH,
    AITIME_POST,
    AITIME_RUN
  } aitime_acq_t;

  // external terminal inputs
  typedef struct packed {
    logic begin_trig;
    logic stop_trig;
    logic scan_ext;
    logic conv_ext;
    logic scan_tb;
    logic ctr_out;
  } aitime_term_t;

  // routed outputs
  typedef struct packed {
    logic conv_strobe_n;
    logic scan_strobe;
    logic hold_done;
    logic begin_pulse;
    logic stop_pulse;
  } aitime_route_t;

endpackage : aitime_pkg

/* File: testbench/aitime_assertions.sv */
// checker: port-level assertions for the analog input timing engine
`timescale 1ns/1ns
module aitime_assertions
  import aitime_pkg::*;
(
  input wire logic          clock_i,
  input wire logic          rst_i,
  input wire aitime_route_t route_o,
  input wire logic          adc_start_o,
  input wire logic          acq_active_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // a scan strobe is only legal once the previous scan saw a conversion; idle counts as settled
  logic conv_seen_r;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      conv_seen_r <= 1'b1;
    else if (route_o.scan_strobe && !adc_start_o)
      conv_seen_r <= 1'b0;
    else if (adc_start_o || !acq_active_o)
      conv_seen_r <= 1'b1;
  end

  AST_CONV_LOW: assert property (
    adc_start_o |-> !route_o.conv_strobe_n) else $error("conversion strobe not low with start");
  AST_CONV_PULSE: assert property (
    $fell(route_o.conv_strobe_n) |=> route_o.conv_strobe_n) else $error("conversion strobe too long");
  AST_HOLD_AFTER: assert property (
    adc_start_o |=> route_o.hold_done != $past(route_o.hold_done)) else $error("no hold-done pulse");
  AST_ONE_CONV: assert property (
    adc_start_o |=> !adc_start_o) else $error("conversion start not single");
  AST_GATED: assert property (
    adc_start_o |-> acq_active_o || $past(acq_active_o)) else $error("conversion while idle");
  AST_SCAN_GATE: assert property (
    route_o.scan_strobe |-> conv_seen_r || adc_start_o) else $error("scan accepted mid-scan");
  AST_BEGIN_PULSE: assert property (
    route_o.begin_pulse |=> !route_o.begin_pulse) else $error("begin pulse too long");
  AST_BEGIN_RUN: assert property (
    route_o.begin_pulse |-> ##[0:3] acq_active_o) else $error("begin pulse without start");
  AST_STOP_PULSE: assert property (
    route_o.stop_pulse |=> !route_o.stop_pulse) else $error("stop pulse too long");
endmodule : aitime_assertions

bind aitime_engine aitime_assertions u_aitime_assertions (
  .clock_i(clock_i), .rst_i(rst_i), .route_o(route_o), .adc_start_o(adc_start_o),
  .acq_active_o(acq_active_o));

/* File: testbench/aitime_partner.sv */
// partner: trigger and clock sources that drive the engine terminals
`timescale 1ns/1ns
module aitime_partner
  import aitime_pkg::*;
(
  input  wire logic         clock_i,
  input  wire logic [5:0]   kick_i,
  input  wire logic [5:0]   idle_i,
  output aitime_term_t      term_o
);
  // a kick leaves idle for three cycles, wide enough to pass the two-flop sync
  logic [5:0] k1_r = 6'h0;
  logic [5:0] k2_r = 6'h0;
  logic [5:0] k3_r = 6'h0;
  logic [1:0] tb_r = 2'h0;
  always_ff @(posedge clock_i) begin
    k1_r <= kick_i;
    k2_r <= k1_r;
    k3_r <= k2_r;
    tb_r <= tb_r + 2'h1;
  end
  // scan timebase runs free at a quarter of the clock
  assign term_o = aitime_term_t'(((idle_i ^ (k1_r | k2_r | k3_r)) & 6'h3d) | {4'h0, tb_r[1], 1'b0});
endmodule : aitime_partner

/* File: testbench/test_aitime_engine.sv */
// testbench: self-checking run of the analog input timing engine
`timescale 1ns/1ns
module test_aitime_engine
  import aitime_pkg::*;
;
  logic          clock_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          reg_wr_i = 1'b0;
  logic          reg_rd_i = 1'b0;
  logic [3:0]    reg_addr_i = 4'h0;
  logic [31:0]   reg_wdata_i = 32'h0;
  logic [31:0]   reg_rdata_o;
  logic [5:0]    kick_r = 6'h0;
  logic [5:0]    idle_r = 6'h0;
  aitime_term_t  term;
  aitime_route_t route;
  logic          adc, store, discard, active;
  int bad_count = 0, compares = 0, cyc = 0, seed = 32'h8194;
  int n_adc, n_scan, n_store, n_disc, n_beg, n_stop, t_scan = 0, t_adc = 0;
  localparam logic [31:0] src_ext = 32'h120; // scan and conversion both from terminals

  aitime_engine u_aitime_engine (
    .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .term_i(term),
    .route_o(route), .adc_start_o(adc), .sample_store_o(store), .sample_discard_o(discard),
    .acq_active_o(active));
  aitime_partner u_aitime_partner (.clock_i(clock_i), .kick_i(kick_r), .idle_i(idle_r), .term_o(term));

  initial begin
    forever #10 clock_i = ~clock_i;
  end

  // counting on the falling edge keeps clear-and-count free of races
  always @(negedge clock_i) begin
    cyc++;
    n_adc += adc;
    n_scan += route.scan_strobe;
    n_store += store;
    n_disc += discard;
    n_beg += route.begin_pulse;
    n_stop += route.stop_pulse;
    if (route.scan_strobe) t_scan = cyc;
    if (adc && t_adc <= t_scan) t_adc = cyc;
    if (cyc == 6000) begin
      bad_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] bit_at(int n);
    return 32'h1 << n;
  endfunction : bit_at
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %0t seen %0h want %0h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    @(posedge clock_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
    chk(reg_rdata_o, e);
  endtask : rd
  task automatic kick(input int i);
    kick_r[i] <= 1'b1;
    @(posedge clock_i);
    kick_r[i] <= 1'b0;
    repeat (8) @(posedge clock_i);
  endtask : kick
  task automatic clr();
    {n_adc, n_scan, n_store, n_disc, n_beg, n_stop} = '0;
  endtask : clr
  task automatic go(input logic [31:0] src);
    wr(AITIME_REG_SRC, src);
    wr(AITIME_REG_CTRL, bit_at(AITIME_CTRL_SW_START));
    repeat (2) @(posedge clock_i);
    chk(active, 1);
  endtask : go
  task automatic stop();
    wr(AITIME_REG_CTRL, bit_at(AITIME_CTRL_SW_STOP));
    repeat (3) @(posedge clock_i);
    chk(active, 0);
  endtask : stop
  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int nc, left, es, ea, d;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    rd(AITIME_REG_CONVDLY, 32'h3);
    rd(4'hf, 32'h0);
    wr(AITIME_REG_SRC, src_ext);
    clr();
    kick(3);
    kick(2);
    chk(n_adc + n_scan, 0);
    $display("done: gating");
    // random scan/conversion streams against an integer gate model, conversion on both edges
    for (int i = 0; i < 6; i++) begin
      nc = 1 + {$random(seed)} % 3;
      {left, es, ea} = '0;
      wr(AITIME_REG_NCHAN, 32'(nc));
      idle_r[2] <= i[0];
      go(src_ext | bit_at(AITIME_SRC_CONTINUOUS) | (i[0] ? bit_at(AITIME_SRC_CONV_FALL) : 32'h0));
      clr();
      repeat (8) begin
        if ({$random(seed)} % 3 == 0) begin
          kick(3);
          es += (left == 0);
          if (left == 0) left = nc;
        end else begin
          kick(2);
          ea += (left > 0);
          if (left > 0) left--;
        end
      end
      chk(n_adc, ea);
      chk(n_scan, es);
      stop();
      idle_r[2] <= 1'b0;
    end
    $display("done: strobe gating");
    go(src_ext | bit_at(AITIME_SRC_SHARED) | bit_at(AITIME_SRC_CONTINUOUS) | bit_at(AITIME_SRC_HOLD_LOW));
    chk(route.hold_done, 1);
    clr();
    repeat (3) kick(2);
    chk(n_adc + n_scan, 6);
    stop();
    $display("done: shared");
    idle_r[5] <= 1'b1;
    wr(AITIME_REG_SRC, src_ext | bit_at(AITIME_SRC_BEGIN_HW) | bit_at(AITIME_SRC_BEGIN_FALL) | bit_at(AITIME_SRC_CONTINUOUS));
    wr(AITIME_REG_CTRL, bit_at(AITIME_CTRL_SW_START));
    repeat (6) @(posedge clock_i);
    chk(active, 0);
    clr();
    kick(5);
    chk(active, 1);
    chk(n_beg, 1);
    stop();
    idle_r[5] <= 1'b0;
    // the trigger pin falling back to idle is an active edge, but nothing is armed now
    repeat (6) @(posedge clock_i);
    chk(active, 0);
    $display("done: begin trigger");
    // internal conversion counter on each conversion timebase, slow enough for the converter
    wr(AITIME_REG_NCHAN, 32'h3);
    wr(AITIME_REG_CONVDIV, 32'h2);
    for (int c = 0; c < 2; c++) begin
      go(bit_at(AITIME_SRC_SCAN_SEL + 1) | bit_at(AITIME_SRC_CONTINUOUS) | (c ? bit_at(AITIME_SRC_CTB_SEL) : 32'h0));
      clr();
      repeat (2) begin
        kick(3);
        repeat (50) @(posedge clock_i);
      end
      d = t_adc - t_scan;
      chk(n_adc, 6);
      chk(d >= 5 + 3 * c && d <= 10 + 6 * c, 1);
      stop();
    end
    $display("done: internal conversion");
    wr(AITIME_REG_BUFSZ, 32'h6);
    wr(AITIME_REG_PRETRIG, 32'h2);
    idle_r[4] <= 1'b1;
    go(src_ext | bit_at(AITIME_SRC_SHARED) | bit_at(AITIME_SRC_STOP_EN) | bit_at(AITIME_SRC_STOP_FALL));
    clr();
    kick(2);
    kick(4);
    repeat (7) kick(2);
    chk(n_disc, 2);
    chk(active, 1);
    kick(4);
    repeat (3) kick(2);
    chk(active, 1);
    kick(2);
    chk(active, 0);
    chk(n_store, 12);
    chk(n_stop, 1);
    idle_r[4] <= 1'b0;
    $display("done: stop trigger");
    wr(AITIME_REG_BUFSZ, 32'h3);
    go(src_ext | bit_at(AITIME_SRC_SHARED));
    repeat (2) kick(2);
    chk(active, 1);
    kick(2);
    chk(active, 0);
    $display("done: finite count");
    summarize();
  end
endmodule : test_aitime_engine
